// ### verilog/irq_steer_core.sv
// Purpose: Cascaded interrupt status readback, PCI line steering and serial interrupt host
// Assumes: All inputs from pins are asynchronous; acknowledges and port strobes are synchronous
// Notes:   Fixed priority, input 0 highest; pending bits latch on a rising request

module irq_steer_core (
  input  wire logic                  core_clk,               // 100 MHz clock
  input  wire logic                  arst_n,                 // Asynchronous reset
  input  wire logic                  io_wr,                  // Command port write strobe
  input  wire logic                  io_rd,                  // Command port read strobe
  input  wire logic                  io_slave,               // Controller select
  input  wire logic                  io_a0,                  // Port select, odd port
  input  wire logic [7:0]            io_wdata,               // Write data
  output logic      [7:0]            io_rdata,               // Read data, registered
  input  wire logic                  int_ack,                // Acknowledge cycle pulse
  output logic                       intr,                   // Interrupt to processor
  output logic      [3:0]            ack_irq,                // Acknowledged input number
  input  wire logic                  cfg_wr,                 // Configuration write strobe
  input  wire logic                  cfg_rd,                 // Configuration read strobe
  input  wire logic [7:0]            cfg_addr,               // Configuration offset
  input  wire logic [7:0]            cfg_wdata,              // Configuration write data
  output logic      [7:0]            cfg_rdata,              // Configuration read data
  input  wire logic [15:0]           legacy_irq,             // Board inputs, active high
  input  wire logic                  rtc_irq,                // Internal clock interrupt
  input  wire logic [irq_steer_pkg::NUM_PCI_LINES-1:0] pci_shared_irq_line_n, // Active low
  input  wire logic                  serirq_in,              // Serial line level
  output logic                       serirq_out,             // Serial line drive value
  output logic                       serirq_oe,              // Serial line drive enable
  output logic                       ext_sys_mgmt_output_n,  // Management request out
  output logic                       io_channel_check_n      // Channel check from frame 17
);
  import irq_steer_pkg::*;

  // Lowest set bit wins: input 0 has the highest priority
  function automatic logic [3:0] first_set(input logic [7:0] v);
    first_set = PRIO_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b0, 3'(i)};
      end
    end
  endfunction : first_set

  // Turns a 3-bit level into a one-hot byte
  function automatic logic [7:0] onehot(input logic [2:0] idx);
    onehot = 8'h01 << idx;
  endfunction : onehot

  // Steering multiplexer: each enabled line sets its target; illegal targets are dropped
  function automatic logic [15:0] route_or(input logic [NUM_PCI_LINES-1:0][7:0] rt,
                                           input logic [NUM_PCI_LINES-1:0]      act);
    logic [15:0] r;
    r = '0;
    for (int l = 0; l < NUM_PCI_LINES; l++) begin
      if (act[l] && !rt[l][ROUTE_DIS_BIT]) begin
        r[rt[l][ROUTE_TGT_MSB:0]] = 1'b1;
      end
    end
    route_or = r & ROUTE_VALID;
  endfunction : route_or

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  localparam int SW = 16 + NUM_PCI_LINES;
  localparam logic [SW-1:0] SYNC_RST = {{NUM_PCI_LINES{1'b1}}, 16'h0000};
  logic [SW-1:0] s1_q, s2_q, s3_q, filt_q;           // Sync chain and filtered level
  logic [SW-1:0] filt_d;                             // Next filtered level
  logic          sr1_q, sr2_q, sr3_q;                // Serial line chain

  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));

  // Second stage alone reads the first; agreement filter rides on stages two and three
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q   <= SYNC_RST;
      s2_q   <= SYNC_RST;
      s3_q   <= SYNC_RST;
      filt_q <= SYNC_RST;
    end else begin
      s1_q   <= {pci_shared_irq_line_n, legacy_irq};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // Serial line: a sample phase is one clock wide, so an agreement filter would eat it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sr1_q <= 1'b1;
      sr2_q <= 1'b1;
      sr3_q <= 1'b1;
    end else begin
      sr1_q <= serirq_in;
      sr2_q <= sr1_q;
      sr3_q <= sr2_q;
    end
  end

  // Configuration registers
  logic [NUM_PCI_LINES-1:0][7:0] route_q;            // Per-line route control
  logic [7:0]                    sirq_ctrl_q;        // Serial engine control
  logic [7:0]                    rtc_sel_q;          // Clock source select
  logic [7:0]                    cfg_val;            // Read mux
  logic [31:0]                   ser_n_q;            // Held frame levels, active low
  logic                          cont_mode_q;        // Continuous mode active
  wire  [7:0] route_idx = cfg_addr - CFG_ROUTE_BASE;
  wire        route_hit = cfg_addr >= CFG_ROUTE_BASE &&
                          route_idx < 8'(NUM_PCI_LINES);

  // Unmapped offsets read as zero
  assign cfg_val = route_hit ? route_q[route_idx[1:0]] :
                   cfg_addr == CFG_SIRQ_CTRL ? sirq_ctrl_q :
                   cfg_addr == CFG_RTC_SEL ? rtc_sel_q : 8'h00;

  // Register writes and registered readback
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      route_q     <= {NUM_PCI_LINES{ROUTE_RST}};
      sirq_ctrl_q <= SIRQ_CTRL_RST;
      rtc_sel_q   <= RTC_SEL_RST;
      cfg_rdata   <= 8'h00;
    end else begin
      if (cfg_wr && route_hit) begin
        route_q[route_idx[1:0]] <= cfg_wdata;
      end
      if (cfg_wr && cfg_addr == CFG_SIRQ_CTRL) begin
        sirq_ctrl_q <= cfg_wdata;
      end
      if (cfg_wr && cfg_addr == CFG_RTC_SEL) begin
        rtc_sel_q <= cfg_wdata;
      end
      if (cfg_rd) begin
        cfg_rdata <= cfg_val;
      end
    end
  end

  // Request assembly: pins, steered PCI lines and held serial levels
  wire [NUM_PCI_LINES-1:0] pci_act = ~filt_q[SW-1:16] |
                                     ~ser_n_q[FR_PCI_A +: NUM_PCI_LINES];
  wire [15:0] routed  = route_or(route_q, pci_act);
  wire        irq8_in = rtc_sel_q[RTC_SEL_BIT] ? !ser_n_q[FR_IRQ8] : rtc_irq;
  wire [15:0] ser_req = (~ser_n_q[15:0] & SER_IRQ_MASK);
  wire [15:0] req_all = filt_q[15:0] | routed | ser_req;

  // Controller state, index 0 master, index 1 slave
  logic [NUM_CTL-1:0][7:0] irr_q, isr_q, imr_q, prev_q; // Pending, service, mask, last req
  logic [NUM_CTL-1:0]      sel_isr_q;                    // Read select: 1 in-service
  logic [NUM_CTL-1:0][7:0] ctl_req, irr_set, ack_mask, eoi_mask;
  logic [NUM_CTL-1:0][3:0] cand, top;
  logic [NUM_CTL-1:0]      ok, take, wr_even, icw1;

  assign ctl_req[CTL_SLAVE]  = {req_all[15:9], irq8_in};
  assign ctl_req[CTL_MASTER] = {req_all[7:3], ok[CTL_SLAVE], req_all[1:0]};
  wire casc = cand[CTL_MASTER][2:0] == CASCADE_LINE;
  assign take[CTL_MASTER] = int_ack && ok[CTL_MASTER];
  assign take[CTL_SLAVE]  = take[CTL_MASTER] && casc && ok[CTL_SLAVE];

  // Per-controller decode: priority, acknowledge and end-of-interrupt masks
  for (genvar c = 0; c < NUM_CTL; c++) begin : g_ctl
    assign irr_set[c]  = ctl_req[c] & ~prev_q[c];
    assign cand[c]     = first_set(irr_q[c] & ~imr_q[c]);
    assign top[c]      = first_set(isr_q[c]);
    assign ok[c]       = !cand[c][3] && (top[c][3] || cand[c][2:0] < top[c][2:0]);
    assign ack_mask[c] = take[c] ? onehot(cand[c][2:0]) : 8'h00;
    assign wr_even[c]  = io_wr && !io_a0 && io_slave == c;
    assign icw1[c]     = wr_even[c] && io_wdata[ICW1_BIT];
    assign eoi_mask[c] = !wr_even[c] || io_wdata[ICW1_BIT] || io_wdata[OP_COMMAND_WORD_THREE_BIT] ? 8'h00 :
                         io_wdata[7:5] == EOI_SPEC ? onehot(io_wdata[2:0]) :
                         io_wdata[7:5] == EOI_NONSPEC && !top[c][3] ?
                         onehot(top[c][2:0]) : 8'h00;

    // Set wins over clear so a request in the acknowledge cycle is kept
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        irr_q[c]     <= 8'h00;
        isr_q[c]     <= 8'h00;
        imr_q[c]     <= 8'h00;
        prev_q[c]    <= 8'h00;
        sel_isr_q[c] <= 1'b0;
      end else begin
        prev_q[c] <= ctl_req[c];
        irr_q[c]  <= icw1[c] ? 8'h00 : (irr_q[c] & ~ack_mask[c]) | irr_set[c];
        isr_q[c]  <= icw1[c] ? 8'h00 : (isr_q[c] & ~eoi_mask[c]) | ack_mask[c];
        if (io_wr && io_a0 && io_slave == c) begin
          imr_q[c] <= io_wdata;
        end else if (icw1[c]) begin
          imr_q[c] <= 8'h00;
        end
        // Selection survives any number of reads
        if (icw1[c]) begin
          sel_isr_q[c] <= 1'b0;
        end else if (wr_even[c] && io_wdata[OP_COMMAND_WORD_THREE_BIT] && io_wdata[RR_BIT]) begin
          sel_isr_q[c] <= io_wdata[RIS_BIT];
        end
      end
    end
  end

  assign intr = ok[CTL_MASTER];
  wire [7:0] rd_val = io_a0 ? imr_q[io_slave] :
                      sel_isr_q[io_slave] ? isr_q[io_slave] : irr_q[io_slave];

  // Port readback and acknowledged number
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata <= 8'h00;
      ack_irq  <= SPURIOUS_IRQ;
    end else begin
      if (io_rd) begin
        io_rdata <= rd_val;
      end
      if (int_ack) begin
        ack_irq <= take[CTL_SLAVE] ? {1'b1, cand[CTL_SLAVE][2:0]} :
                   take[CTL_MASTER] ? {1'b0, cand[CTL_MASTER][2:0]} : SPURIOUS_IRQ;
      end
    end
  end

  // Serial interrupt engine
  sirq_state_t state_q;                              // Engine state
  logic [6:0]  cnt_q;                                // Clock count within state
  logic [SER_LAT-1:0]      samp_v_q;                 // Sample strobe delay line
  logic [SER_LAT-1:0][4:0] samp_i_q;                 // Frame index delay line
  wire [2:0] extra    = sirq_ctrl_q[2:0] < START_EXTRA_MIN ? START_EXTRA_MIN :
                        sirq_ctrl_q[2:0];
  wire [6:0] start_ln = {4'h0, extra} + {6'h00, cont_mode_q};
  wire [6:0] stop_ln  = sirq_ctrl_q[SIRQ_CONT_BIT] ? STOP_LONG : STOP_SHORT;
  wire [6:0] rel      = cnt_q - FRAME_FIRST;
  wire [6:0] fr_idx   = rel / FRAME_STRIDE;
  wire       samp_now = state_q == SIRQ_DATA && cnt_q >= FRAME_FIRST &&
                        rel % FRAME_STRIDE == 7'h00 && fr_idx < NUM_FRAMES;
  wire       host_go  = sirq_ctrl_q[SIRQ_EN_BIT] &&
                        (cont_mode_q || sirq_ctrl_q[SIRQ_CONT_BIT]);
  wire       periph_go = sirq_ctrl_q[SIRQ_EN_BIT] && !cont_mode_q && !sr3_q;

  // Open collector: low in start and stop, one high clock each, released otherwise
  assign serirq_oe  = state_q == SIRQ_START || state_q == SIRQ_STOP ||
                      state_q == SIRQ_STOP_HI || (state_q == SIRQ_DATA && cnt_q == 7'h00);
  assign serirq_out = state_q == SIRQ_STOP_HI || state_q == SIRQ_DATA;

  // Frame sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= SIRQ_IDLE;
      cnt_q       <= 7'h00;
      cont_mode_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      case (state_q)
        SIRQ_IDLE: begin
          cnt_q <= 7'h00;
          if (host_go || periph_go) begin
            state_q <= SIRQ_START;
          end
        end
        SIRQ_START: begin
          if (cnt_q + 7'h01 >= start_ln) begin
            state_q <= SIRQ_DATA;
            cnt_q   <= 7'h00;
          end
        end
        SIRQ_DATA: begin
          if (cnt_q == DATA_CLOCKS - 7'h01) begin
            state_q <= SIRQ_STOP;
            cnt_q   <= 7'h00;
          end
        end
        SIRQ_STOP: begin
          // Greater-or-equal so a control write mid-stop cannot strand the line low
          if (cnt_q + 7'h01 >= stop_ln) begin
            state_q     <= SIRQ_STOP_HI;
            // Mode follows the low length really driven, not the control bit alone
            cont_mode_q <= cnt_q + 7'h01 == STOP_LONG;
          end
        end
        SIRQ_STOP_HI: begin
          state_q <= SIRQ_GAP;
          cnt_q   <= 7'h00;
        end
        SIRQ_GAP: begin
          // Wait until the synchroniser no longer shows our own stop low,
          // otherwise quiet mode would see a false peripheral start
          if (cnt_q == 7'(SER_LAT - 2)) begin
            state_q <= SIRQ_IDLE;
          end
        end
        default: begin
          state_q <= SIRQ_IDLE;
        end
      endcase
    end
  end

  // Sample strobes wait out the pin synchroniser before latching a frame level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_v_q <= '0;
      samp_i_q <= '0;
      ser_n_q  <= SER_IDLE;
    end else begin
      samp_v_q <= {samp_v_q[SER_LAT-2:0], samp_now};
      samp_i_q <= {samp_i_q[SER_LAT-2:0], fr_idx[4:0]};
      if (samp_v_q[SER_LAT-1]) begin
        ser_n_q[samp_i_q[SER_LAT-1]] <= sr3_q;
      end
    end
  end

  assign ext_sys_mgmt_output_n = ser_n_q[FR_SMI];
  assign io_channel_check_n    = ser_n_q[FR_IOCHK];

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] low_run_q;                             // Consecutive host-driven low clocks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_run_q <= 4'h0;
    end else begin
      low_run_q <= (serirq_oe && !serirq_out) ? low_run_q + 4'h1 : 4'h0;
    end
  end

  a_status_read: assert property (io_rd && !io_a0 |=> io_rdata ==
    ($past(sel_isr_q[io_slave]) ? $past(isr_q[io_slave]) : $past(irr_q[io_slave])))
    else $error("status read returned wrong register");
  a_mask_read: assert property (io_rd && io_a0 |=> io_rdata == $past(imr_q[io_slave]))
    else $error("mask read mismatch");
  a_ack_clears_irr: assert property (take[0] && !casc &&
    !irr_set[0][cand[0][2:0]] |=> !irr_q[0][$past(cand[0][2:0])])
    else $error("acknowledge did not clear pending bit");
  a_ack_sets_isr: assert property (take[0] && !casc && !icw1[0] |=>
    isr_q[0][$past(cand[0][2:0])] && ack_irq == {1'b0, $past(cand[0][2:0])})
    else $error("acknowledge did not set in-service bit");
  a_init_sel_irr: assert property (icw1[1] |=> !sel_isr_q[1] ##1
    (sel_isr_q[1] == $past(wr_even[1] && io_wdata[OP_COMMAND_WORD_THREE_BIT] && io_wdata[RR_BIT]
      && io_wdata[RIS_BIT] && !io_wdata[ICW1_BIT])))
    else $error("read selection not reset by initialisation");
  a_route_legal: assert property (!route_q[0][ROUTE_DIS_BIT] && pci_act[0] &&
    ROUTE_VALID[route_q[0][ROUTE_TGT_MSB:0]] |-> routed[route_q[0][ROUTE_TGT_MSB:0]])
    else $error("enabled route did not reach its input");
  a_mask_blocks: assert property (imr_q[0][CASCADE_LINE] |-> !take[1])
    else $error("slave served with cascade input masked");
  a_start_low: assert property ($fell(serirq_oe && !serirq_out) && state_q == SIRQ_DATA |->
    low_run_q >= 4'(START_EXTRA_MIN) && low_run_q <= 4'h8)
    else $error("start frame low length out of range");
  a_data_release: assert property (state_q == SIRQ_DATA && cnt_q != 7'h00 |-> !serirq_oe)
    else $error("host drove line inside data frames");
  a_stop_len: assert property ($rose(state_q == SIRQ_STOP) |->
    (state_q == SIRQ_STOP)[*2] ##1 (state_q == SIRQ_STOP || state_q == SIRQ_STOP_HI))
    else $error("stop frame shorter than two clocks");
  a_smi_out: assert property (samp_v_q[SER_LAT-1] && samp_i_q[SER_LAT-1] == 5'(FR_SMI)
    && !sr3_q |=> !ext_sys_mgmt_output_n)
    else $error("management output missed frame 3");
  a_quiet_next: assert property (state_q == SIRQ_STOP && cnt_q == 7'h01 &&
    !sirq_ctrl_q[SIRQ_CONT_BIT] |=> !cont_mode_q)
    else $error("short stop did not select quiet mode");
  c_cascade_ack: cover property (take[1]);
  c_quiet_start: cover property (state_q == SIRQ_IDLE && periph_go);
  c_full_cycle: cover property (state_q == SIRQ_STOP ##[1:4] state_q == SIRQ_GAP);
endmodule : irq_steer_core

// ### verilog/irq_steer_pkg.sv
// Purpose: Shared constants for the interrupt status, steering and serial interrupt block
// Assumes: Single 100 MHz core clock, byte-wide register ports
// Notes:   Offsets, control bit positions, configuration reset values and frame figures live here
package irq_steer_pkg;
  // Clock
  localparam int          CLK_PERIOD_NS   = 10;          // 100 MHz core clock
  // Cascaded controller layout
  localparam int          NUM_CTL         = 2;           // Master and slave controllers
  localparam logic        CTL_MASTER      = 1'b0;        // Master controller index
  localparam logic        CTL_SLAVE       = 1'b1;        // Slave controller index
  localparam logic [2:0]  CASCADE_LINE    = 3'h2;        // Master input fed by slave
  localparam logic [3:0]  PRIO_NONE       = 4'h8;        // Priority search found nothing
  localparam logic [3:0]  SPURIOUS_IRQ    = 4'h7;        // Vector given when nothing pends
  // Command byte decode on the even port
  localparam int          ICW1_BIT        = 4;           // Set: initialisation word
  localparam int          OP_COMMAND_WORD_THREE_BIT        = 3;           // Set with bit 4 clear: read select
  localparam int          RR_BIT          = 1;           // Read register command
  localparam int          RIS_BIT         = 0;           // 0 pending, 1 in-service
  localparam logic [2:0]  EOI_NONSPEC     = 3'h1;        // Bits 7:5 non-specific end
  localparam logic [2:0]  EOI_SPEC        = 3'h3;        // Bits 7:5 specific end
  // PCI line steering
  localparam int          NUM_PCI_LINES   = 4;           // Shared PCI lines A to D
  localparam int          ROUTE_DIS_BIT   = 7;           // Route disable
  localparam int          ROUTE_TGT_MSB   = 3;           // Target field is 3:0
  localparam logic [15:0] ROUTE_VALID     = 16'hDEF8;    // Inputs 3-7, 9-12, 14, 15
  localparam logic [7:0]  ROUTE_RST       = 8'h80;       // Disabled after reset
  // Configuration offsets
  localparam logic [7:0]  CFG_ROUTE_BASE  = 8'h60;       // Route A; B to D follow
  localparam logic [7:0]  CFG_SIRQ_CTRL   = 8'h64;       // Serial interrupt control
  localparam logic [7:0]  CFG_RTC_SEL     = 8'h66;       // Real-time-clock source select
  localparam logic [7:0]  RTC_SEL_RST     = 8'h00;       // Internal source after reset
  localparam int          RTC_SEL_BIT     = 0;           // Set: frame 9 drives input 8
  // Serial interrupt control fields
  localparam int          SIRQ_EN_BIT     = 7;           // Serial engine enable
  localparam int          SIRQ_CONT_BIT   = 6;           // Set: 3-clock stop, continuous
  localparam logic [7:0]  SIRQ_CTRL_RST   = 8'hC4;       // Enabled, continuous, 4 extra
  localparam logic [2:0]  START_EXTRA_MIN = 3'h3;        // Host start clocks, quiet mode
  localparam logic [2:0]  START_EXTRA_MAX = 3'h7;
  // Serial frame timing, counted from the start frame's high clock
  localparam logic [6:0]  FRAME_FIRST     = 7'h02;       // First sample clock
  localparam logic [6:0]  FRAME_STRIDE    = 7'h03;       // Sample, recovery, turn-around
  localparam logic [6:0]  NUM_FRAMES      = 7'h20;       // Frames 1 to 32
  localparam logic [6:0]  DATA_CLOCKS     = 7'h62;       // 2 + 32 * 3
  localparam logic [6:0]  STOP_SHORT      = 7'h02;       // Quiet next
  localparam logic [6:0]  STOP_LONG       = 7'h03;       // Continuous next
  localparam int          SER_LAT         = 3;           // Pin synchroniser depth
  // Frame indices (frame number minus one)
  localparam int          FR_SMI          = 2;
  localparam int          FR_IRQ8         = 8;
  localparam int          FR_IOCHK        = 16;
  localparam int          FR_PCI_A        = 17;
  localparam logic [15:0] SER_IRQ_MASK    = 16'hDEFA;    // Frames carrying inputs 1, 3-7, 9-12, 14, 15
  localparam logic [31:0] SER_IDLE        = 32'hFFFF_FFFF; // All frames inactive

  // Serial engine states
  typedef enum logic [2:0] {
    SIRQ_IDLE, SIRQ_START, SIRQ_DATA, SIRQ_STOP, SIRQ_STOP_HI, SIRQ_GAP
  } sirq_state_t;
endpackage : irq_steer_pkg

// ### tb/sirq_peripheral.sv
// Purpose: Serial interrupt peripheral model that reports one data frame
// Assumes: The line level it sees is already resolved with the pull-up
// Notes:   Low runs of four or more clocks are starts; shorter runs are stops, so a
// three-clock host start would be misread. Clock never stops here
module sirq_peripheral #(
  parameter int FRAME = 2                  // Frame index, frame number minus one
) (
  input  wire logic core_clk,              // 100 MHz clock
  input  wire logic arst_n,                // Asynchronous reset
  input  wire logic active,                // Interrupt to report
  input  wire logic line,                  // Resolved serial line
  output logic      pull_low               // Open-collector drive, never high
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLOT = 7'(2 + 3 * FRAME); // Sample clock of our frame
  logic [3:0] low_q;                       // Length of the current low run
  logic [6:0] cnt_q;                       // Clocks since start frame rise
  logic       quiet_q;                     // Last stop was two clocks: quiet mode
  // Only a long low run restarts the count, so a stop rise is not taken as a start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 4'h0;
      cnt_q <= 7'h7F;
      quiet_q <= 1'b0;
    end else begin
      low_q <= line ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
      // A two-clock stop opens quiet mode; any later low closes it
      quiet_q <= line && (low_q == 4'h2 || (low_q == 4'h0 && quiet_q));
      if (line && low_q >= 4'h4) cnt_q <= 7'h01; // Count from rising edge
      else if (cnt_q != 7'h7F) cnt_q <= cnt_q + 7'h01;
    end
  end
  // Drive only in our sample phase or in quiet mode, released otherwise
  // In quiet mode an active request pulls one clock to wake the host
  assign pull_low = active && (cnt_q == SLOT || quiet_q);
endmodule : sirq_peripheral

// ### tb/testbench.sv
// Purpose: Self-checking bench for status readback, steering and serial frames
// Assumes: Both controllers reached; one peripheral reports the management frame
// Notes:   Command and config accesses are one-cycle strobes, data the cycle after
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_steer_pkg::*;
  logic core_clk = 0, arst_n = 0, io_wr = 0, io_rd = 0, io_a0 = 0, int_ack = 0;
  logic cfg_wr = 0, cfg_rd = 0, act = 0, sl = 0, so, soe, pl, ext_n, chk_n, intr;
  logic [7:0] io_wdata = 0, cfg_addr = 0, cfg_wdata = 0, io_rdata, cfg_rdata;
  logic [15:0] legacy_irq = 0;
  logic [3:0] pci_n = 4'hF, ack_irq;
  int errors = 0, tests_run = 0, cyc = 0;
  wire line = !((soe && !so) || pl);      // Pull-up resolves the shared line
  irq_steer_core dut_u (.core_clk(core_clk), .arst_n(arst_n), .io_wr(io_wr), .io_rd(io_rd),
    .io_slave(sl), .io_a0(io_a0), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .int_ack(int_ack), .intr(intr), .ack_irq(ack_irq), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .legacy_irq(legacy_irq), .rtc_irq(1'b0), .pci_shared_irq_line_n(pci_n),
    .serirq_in(line), .serirq_out(so), .serirq_oe(soe),
    .ext_sys_mgmt_output_n(ext_n), .io_channel_check_n(chk_n));
  sirq_peripheral #(.FRAME(FR_SMI)) peer_u (.core_clk(core_clk), .arst_n(arst_n),
    .active(act), .line(line), .pull_low(pl));
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  // Watchdog: the whole sequence needs about 1600 cycles
  always @(posedge core_clk) if (++cyc == 4000) begin errors++; finish_test(); end
  task automatic io(input logic a0, input logic [7:0] d);
    @(posedge core_clk) begin io_a0 <= a0; io_wdata <= d; io_wr <= 1; end
    @(posedge core_clk) io_wr <= 0;
  endtask : io
  task automatic io_chk(input logic a0, input logic [7:0] e);
    @(posedge core_clk) begin io_a0 <= a0; io_rd <= 1; end
    @(posedge core_clk) io_rd <= 0;
    #1 `CHK(io_rdata, e)
  endtask : io_chk
  task automatic cfg(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge core_clk) begin cfg_addr <= a; cfg_wdata <= d; cfg_wr <= !rd; cfg_rd <= rd; end
    @(posedge core_clk) begin cfg_wr <= 0; cfg_rd <= 0; end
    #1 if (rd) `CHK(cfg_rdata, d)
  endtask : cfg
  task automatic ack(input logic [3:0] e);
    @(posedge core_clk) int_ack <= 1;
    @(posedge core_clk) int_ack <= 0;
    #1 `CHK(ack_irq, e)
  endtask : ack
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1;
    `CHK(ack_irq, SPURIOUS_IRQ)
    cfg(CFG_ROUTE_BASE, ROUTE_RST, 1);
    cfg(CFG_SIRQ_CTRL, SIRQ_CTRL_RST, 1);
    cfg(CFG_RTC_SEL, RTC_SEL_RST, 1);
    cfg(8'h70, 8'h00, 1);
    io(1, 8'hA5);
    io_chk(1, 8'hA5);
    io(1, 8'h00);
    legacy_irq[5] <= 1;
    repeat (10) @(posedge core_clk);
    `CHK(intr, 1'b1)
    io_chk(0, 8'h20);
    ack(4'h5);
    io(0, 8'h0B);
    io_chk(0, 8'h20);
    io_chk(0, 8'h20);
    io(0, 8'h20);
    io_chk(0, 8'h00);
    io(0, 8'h0A);
    io_chk(0, 8'h00);
    cfg(CFG_ROUTE_BASE, 8'h06, 0);
    pci_n[0] <= 0;
    repeat (10) @(posedge core_clk);
    io_chk(0, 8'h40);
    io(1, 8'h04);
    legacy_irq[9] <= 1;
    repeat (10) @(posedge core_clk);
    ack(4'h6);
    io(1, 8'h00);
    ack(4'h9);
    sl <= 1;
    io(0, 8'h0B);
    io_chk(0, 8'h02);
    io(0, 8'h11);
    legacy_irq[10] <= 1;
    repeat (10) @(posedge core_clk);
    io_chk(0, 8'h04);
    sl <= 0;
    act <= 1;
    repeat (300) @(posedge core_clk);
    `CHK(ext_n, 1'b0)
    act <= 0;
    repeat (300) @(posedge core_clk);
    `CHK(ext_n, 1'b1)
    `CHK(chk_n, 1'b1)
    cfg(CFG_SIRQ_CTRL, 8'h84, 0);
    repeat (200) @(posedge core_clk);
    repeat (120) @(negedge core_clk) `CHK(soe, 1'b0)
    @(posedge core_clk) act <= 1;
    repeat (300) @(posedge core_clk);
    `CHK(ext_n, 1'b0)
    act <= 0;
    cfg(CFG_SIRQ_CTRL, SIRQ_CTRL_RST, 0);
    repeat (300) @(posedge core_clk);
    `CHK(ext_n, 1'b1)
    finish_test();
  end
endmodule : testbench
